/* File: hw/acs_pkg.sv */
// acs_pkg: constants and carriers for the converter status, reference and trigger block
// assumes: one system clock; word-addressed Avalon-MM register bus
package acs_pkg;

   // ==========================================================================
   // register indices (byte address = 4 * index)
   // ==========================================================================
   localparam logic [9:0] IDX_STATUS    = 10'h115;
   localparam logic [9:0] IDX_REFSEL    = 10'h116;
   localparam logic [9:0] IDX_TRIGSEL   = 10'h117;
   localparam logic [9:0] IDX_CTRL      = 10'h120;
   localparam logic [9:0] IDX_IRQ_STAT  = 10'h121;
   localparam logic [9:0] IDX_IRQ_MASK  = 10'h122;

   // ==========================================================================
   // field positions and reset values
   // ==========================================================================
   localparam int         ST_OV_BIT     = 7;
   localparam int         ST_UPPER_BIT  = 6;
   localparam int         ST_LOWER_BIT  = 5;
   localparam int         ST_COMPUTATION_UPDATED_FLAG_BIT   = 4;
   localparam int         REF_NEG_BIT   = 4;
   localparam int         CTRL_EN_BIT   = 0;
   localparam int         CTRL_DSEN_BIT = 3;
   localparam int         CTRL_CALC_LSB = 4;
   localparam logic [7:0] STATUS_RST    = 8'h00;
   localparam logic [7:0] REFSEL_RST    = 8'h00;
   localparam logic [4:0] TRIGSEL_RST   = 5'h00;
   localparam logic [7:0] CTRL_RST      = 8'h00;
   localparam logic [4:0] IRQ_RST       = 5'h00;

   // irq status bits
   localparam int IRQ_START = 0;
   localparam int IRQ_UPPER = 1;
   localparam int IRQ_LOWER = 2;
   localparam int IRQ_OV    = 3;
   localparam int IRQ_COMPUTATION_UPDATED_FLAG  = 4;

   // ==========================================================================
   // codes
   // ==========================================================================
   localparam logic [4:0] TRG_OFF       = 5'h00;
   localparam logic [4:0] TRG_IOC_OR    = 5'h13;
   localparam logic [4:0] TRG_RSV_LO    = 5'h1a;
   localparam logic [4:0] TRG_ERR_RD    = 5'h1c;
   localparam logic [4:0] TRG_RES_RD    = 5'h1d;
   localparam logic [4:0] TRG_CHAN_WR   = 5'h1f;
   localparam logic [2:0] STAGE_UNUSED  = 3'h4;
   localparam logic [2:0] CALC_RES_PREV = 3'h0;
   localparam logic [2:0] CALC_RES_SET  = 3'h1;
   localparam logic [2:0] CALC_RES_FLT  = 3'h2;
   localparam logic [2:0] CALC_PREV_FLT = 3'h4;
   localparam logic [2:0] CALC_FLT_SET  = 3'h5;

   localparam int DW = 16;

   typedef enum logic [0:0] {BUS_IDLE = 1'b0, BUS_ACK = 1'b1} acs_bus_e;

   // datapath values handed in by the conversion engine
   typedef struct packed {
      logic signed [DW-1:0] result;
      logic signed [DW-1:0] prev;
      logic signed [DW-1:0] setpoint;
      logic signed [DW-1:0] filter;
      logic signed [DW-1:0] upper_thr;
      logic signed [DW-1:0] lower_thr;
      logic                 accum_ovf;
      logic                 compute_done;
   } acs_dp_s;

endpackage : acs_pkg

/* File: hw/acs_status_trig.sv */
// acs_status_trig: status flags, reference select and auto-trigger select for the converter
// assumes: datapath, trigger lines and core strobes are on mclk_in; master holds requests until waitrequest low
//
// Behaviour
// - status bit 7 shows accumulator or error calculation overflow, clear otherwise
// - status bit 6 is one when error exceeds upper threshold
// - status bit 5 is one when error is below lower threshold
// - status bit 4 sets when computation registers or overflow update
// - once cleared, bit 4 stays zero until those values change again
// - 3-bit stage code reports converter phase; code 100 never reported
// - stage code may be invalid with rc clock and slower system oscillator
// - reference bit 4 picks external negative reference, else analog ground
// - positive reference field: 11 fixed ref, 10 external, 00 supply, 01 reserved
// - trigger register bits 4:0 choose the auto conversion start event
// - code 11111 starts conversion on software write of channel select
// - codes 11101 and 11100 start on result or error high byte reads
// - code 10011 uses the OR of all change interrupt flags
// - logic cell, comparator and capture-compare triggers map to their codes
// - error value is formed per the 3-bit error calculation mode
`timescale 1ns/1ps
`default_nettype none

module acs_status_trig (
   // clock and reset
   input  wire  logic                 mclk_in,
   input  wire  logic                 rst_in,
   // avalon-mm slave
   input  wire  logic [9:0]           avs_address_in,
   input  wire  logic                 avs_read_in,
   input  wire  logic                 avs_write_in,
   input  wire  logic [31:0]          avs_writedata_in,
   input  wire  logic [3:0]           avs_byteenable_in,
   output var   logic [31:0]          avs_readdata_out,
   output var   logic                 avs_waitrequest_out,
   // conversion datapath
   input  wire  acs_pkg::acs_dp_s     dp_in,
   input  wire  logic [2:0]           stage_in,
   input  wire  logic                 rc_clk_sel_in,
   input  wire  logic                 fosc_slower_in,
   // trigger sources
   input  wire  logic [31:0]          trig_lines_in,
   input  wire  logic [7:0]           ioc_flags_in,
   input  wire  logic                 chan_sel_wr_in,
   input  wire  logic                 result_high_rd_in,
   input  wire  logic                 error_high_rd_in,
   // converter controls
   output var   logic                 conv_start_out,
   output var   logic                 neg_ref_select_out,
   output var   logic [1:0]           pos_ref_select_out,
   output var   logic                 stage_valid_out,
   output var   logic                 irq_out
);

   // ==========================================================================
   // decode helpers
   // ==========================================================================
   function automatic logic is_hw_code(input logic [4:0] code);
      is_hw_code = (code != acs_pkg::TRG_OFF) && (code < acs_pkg::TRG_RSV_LO);
   endfunction : is_hw_code

   function automatic logic [17:0] sx(input logic [acs_pkg::DW-1:0] v);
      sx = {{(18-acs_pkg::DW){v[acs_pkg::DW-1]}}, v};
   endfunction : sx

   function automatic logic [17:0] calc_err(input logic [2:0] mode, input logic dsen,
                                           input acs_pkg::acs_dp_s d);
      logic [17:0] base;
      base = dsen ? (sx(d.result) - sx(d.prev)) : sx(d.result);
      case (mode)
         acs_pkg::CALC_RES_PREV: calc_err = sx(d.result) - sx(d.prev);
         acs_pkg::CALC_RES_SET:  calc_err = base - sx(d.setpoint);
         acs_pkg::CALC_RES_FLT:  calc_err = base - sx(d.filter);
         acs_pkg::CALC_PREV_FLT: calc_err = sx(d.prev) - sx(d.filter);
         acs_pkg::CALC_FLT_SET:  calc_err = sx(d.filter) - sx(d.setpoint);
         default:                calc_err = 18'h00000;
      endcase
   endfunction : calc_err

   // ==========================================================================
   // registers
   // ==========================================================================
   acs_pkg::acs_bus_e bus_q;
   logic [7:0]        refsel_q;
   logic [4:0]        trigsel_q;
   logic [7:0]        ctrl_q;
   logic [4:0]        irq_stat_q;
   logic [4:0]        irq_mask_q;
   logic              ov_q;
   logic              err_ovf_q;
   logic              upper_q;
   logic              lower_q;
   logic              computation_updated_flag_q;
   logic [2:0]        stage_q;
   logic              sel_level_q;

   logic        req;
   logic        wr_ok;
   logic        rd_take;
   logic        enable;
   logic        ov_d;
   logic        computation_updated_flag_set;
   logic        sel_level;
   logic        trig_event;
   logic [17:0] err_d;
   logic        err_ovf_d;
   logic        above_d;
   logic        below_d;
   logic [4:0]  irq_set;
   logic [7:0]  status_rd;

   assign req     = avs_read_in | avs_write_in;
   assign wr_ok   = avs_write_in && (bus_q == acs_pkg::BUS_ACK) && avs_byteenable_in[0];
   assign rd_take = avs_read_in && (bus_q == acs_pkg::BUS_IDLE);
   assign enable  = ctrl_q[acs_pkg::CTRL_EN_BIT];

   // ==========================================================================
   // bus handshake: one wait cycle, answer on the second
   // ==========================================================================
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         bus_q               <= acs_pkg::BUS_IDLE;
         avs_waitrequest_out <= 1'b1;
      end else if (bus_q == acs_pkg::BUS_IDLE && req) begin
         bus_q               <= acs_pkg::BUS_ACK;
         avs_waitrequest_out <= 1'b0;
      end else begin
         bus_q               <= acs_pkg::BUS_IDLE;
         avs_waitrequest_out <= 1'b1;
      end
   end

   assign status_rd = {ov_q, upper_q, lower_q, computation_updated_flag_q, 1'b0, stage_q};

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         avs_readdata_out <= 32'h00000000;
      end else if (rd_take) begin
         case (avs_address_in)
            acs_pkg::IDX_STATUS:   avs_readdata_out <= {24'h000000, status_rd};
            acs_pkg::IDX_REFSEL:   avs_readdata_out <= {24'h000000, refsel_q};
            acs_pkg::IDX_TRIGSEL:  avs_readdata_out <= {27'h0000000, trigsel_q};
            acs_pkg::IDX_CTRL:     avs_readdata_out <= {24'h000000, ctrl_q};
            acs_pkg::IDX_IRQ_STAT: avs_readdata_out <= {27'h0000000, irq_stat_q};
            acs_pkg::IDX_IRQ_MASK: avs_readdata_out <= {27'h0000000, irq_mask_q};
            default:               avs_readdata_out <= 32'h00000000;
         endcase
      end
   end

   // ==========================================================================
   // configuration registers
   // ==========================================================================
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         refsel_q <= acs_pkg::REFSEL_RST;
      end else if (wr_ok && avs_address_in == acs_pkg::IDX_REFSEL) begin
         refsel_q <= {3'h0, avs_writedata_in[acs_pkg::REF_NEG_BIT], 2'h0, avs_writedata_in[1:0]};
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         trigsel_q <= acs_pkg::TRIGSEL_RST;
      end else if (wr_ok && avs_address_in == acs_pkg::IDX_TRIGSEL) begin
         trigsel_q <= avs_writedata_in[4:0];
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_q <= acs_pkg::CTRL_RST;
      end else if (wr_ok && avs_address_in == acs_pkg::IDX_CTRL) begin
         ctrl_q <= {1'b0, avs_writedata_in[6:3], 2'h0, avs_writedata_in[0]};
      end
   end

   // reference routing to the analog front end
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         neg_ref_select_out <= 1'b0;
         pos_ref_select_out <= 2'h0;
      end else begin
         neg_ref_select_out <= refsel_q[acs_pkg::REF_NEG_BIT];
         pos_ref_select_out <= refsel_q[1:0];
      end
   end

   // ==========================================================================
   // error calculation and threshold flags
   // ==========================================================================
   assign err_d     = calc_err(ctrl_q[acs_pkg::CTRL_CALC_LSB +: 3], ctrl_q[acs_pkg::CTRL_DSEN_BIT],
                               dp_in);
   assign err_ovf_d = (err_d[17:15] != 3'h0) && (err_d[17:15] != 3'h7);
   assign above_d   = $signed(err_d) > $signed(sx(dp_in.upper_thr));
   assign below_d   = $signed(err_d) < $signed(sx(dp_in.lower_thr));

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         err_ovf_q <= 1'b0;
         upper_q   <= 1'b0;
         lower_q   <= 1'b0;
      end else if (dp_in.compute_done) begin
         err_ovf_q <= err_ovf_d;
         upper_q   <= above_d;
         lower_q   <= below_d;
      end
   end

   assign ov_d = dp_in.accum_ovf | err_ovf_q;

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         ov_q <= 1'b0;
      end else begin
         ov_q <= ov_d;
      end
   end

   // computation status: set wins over a software clear
   assign computation_updated_flag_set = dp_in.compute_done | (ov_d != ov_q);

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         computation_updated_flag_q <= 1'b0;
      end else if (computation_updated_flag_set) begin
         computation_updated_flag_q <= 1'b1;
      end else if (wr_ok && avs_address_in == acs_pkg::IDX_STATUS &&
                   !avs_writedata_in[acs_pkg::ST_COMPUTATION_UPDATED_FLAG_BIT]) begin
         computation_updated_flag_q <= 1'b0;
      end
   end

   // ==========================================================================
   // stage code
   // ==========================================================================
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         stage_q         <= 3'h0;
         stage_valid_out <= 1'b1;
      end else begin
         if (stage_in != acs_pkg::STAGE_UNUSED) begin
            stage_q <= stage_in;
         end
         stage_valid_out <= !(rc_clk_sel_in && fosc_slower_in);
      end
   end

   // ==========================================================================
   // trigger selection
   // ==========================================================================
   always_comb begin
      sel_level = 1'b0;
      if (trigsel_q == acs_pkg::TRG_IOC_OR) begin
         sel_level = |ioc_flags_in;
      end else if (is_hw_code(trigsel_q)) begin
         sel_level = trig_lines_in[trigsel_q];
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         sel_level_q <= 1'b0;
      end else begin
         sel_level_q <= sel_level;
      end
   end

   // reserved codes fall through every branch and never fire
   always_comb begin
      case (trigsel_q)
         acs_pkg::TRG_CHAN_WR: trig_event = chan_sel_wr_in;
         acs_pkg::TRG_RES_RD:  trig_event = result_high_rd_in;
         acs_pkg::TRG_ERR_RD:  trig_event = error_high_rd_in;
         default:              trig_event = is_hw_code(trigsel_q) && sel_level && !sel_level_q;
      endcase
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         conv_start_out <= 1'b0;
      end else begin
         conv_start_out <= trig_event && enable;
      end
   end

   // ==========================================================================
   // interrupts
   // ==========================================================================
   assign irq_set = {computation_updated_flag_set && !computation_updated_flag_q, ov_d && !ov_q,
                     dp_in.compute_done && below_d, dp_in.compute_done && above_d,
                     trig_event && enable};

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_stat_q <= acs_pkg::IRQ_RST;
      end else if (wr_ok && avs_address_in == acs_pkg::IDX_IRQ_STAT) begin
         irq_stat_q <= (irq_stat_q & ~avs_writedata_in[4:0]) | irq_set;
      end else begin
         irq_stat_q <= irq_stat_q | irq_set;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_mask_q <= acs_pkg::IRQ_RST;
      end else if (wr_ok && avs_address_in == acs_pkg::IDX_IRQ_MASK) begin
         irq_mask_q <= avs_writedata_in[4:0];
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(irq_stat_q & irq_mask_q);
      end
   end

   // ==========================================================================
   // assertions
   // ==========================================================================
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   sequence s_compute;
      dp_in.compute_done ##1 1'b1;
   endsequence

   property p_ov;
      ##1 ov_q == $past(dp_in.accum_ovf | err_ovf_q);
   endproperty
   a_ov: assert property (p_ov) else $error("overflow flag wrong");

   property p_upper;
      dp_in.compute_done |=> upper_q == $past(above_d);
   endproperty
   a_upper: assert property (p_upper) else $error("upper flag wrong");

   property p_lower;
      dp_in.compute_done |=> lower_q == $past(below_d);
   endproperty
   a_lower: assert property (p_lower) else $error("lower flag wrong");

   property p_computation_updated_flag_set;
      s_compute |-> computation_updated_flag_q;
   endproperty
   a_computation_updated_flag_set: assert property (p_computation_updated_flag_set) else $error("computation flag not set");

   property p_computation_updated_flag_hold;
      !computation_updated_flag_q && !computation_updated_flag_set |=> !computation_updated_flag_q;
   endproperty
   a_computation_updated_flag_hold: assert property (p_computation_updated_flag_hold) else $error("computation flag rose alone");

   property p_stage;
      stage_q != acs_pkg::STAGE_UNUSED;
   endproperty
   a_stage: assert property (p_stage) else $error("unused stage reported");

   property p_negref;
      ##1 neg_ref_select_out == $past(refsel_q[acs_pkg::REF_NEG_BIT]);
   endproperty
   a_negref: assert property (p_negref) else $error("negative reference route wrong");

   property p_chan_wr;
      trigsel_q == acs_pkg::TRG_CHAN_WR && chan_sel_wr_in && enable |=> conv_start_out;
   endproperty
   a_chan_wr: assert property (p_chan_wr) else $error("channel write did not start");

   property p_res_rd;
      trigsel_q == acs_pkg::TRG_RES_RD && result_high_rd_in && enable |=> conv_start_out;
   endproperty
   a_res_rd: assert property (p_res_rd) else $error("result read did not start");

   property p_enable;
      !enable |=> !conv_start_out;
   endproperty
   a_enable: assert property (p_enable) else $error("start while disabled");

   property p_irq;
      ##1 irq_out == $past(|(irq_stat_q & irq_mask_q));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt output wrong");

   property p_bus;
      req && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
   endproperty
   a_bus: assert property (p_bus) else $error("bus answer timing wrong");

endmodule : acs_status_trig

`default_nettype wire

/* File: dv/acs_status_trig_tb.sv */
// acs_status_trig_tb: self-checking bench for status flags, reference select and trigger select
// assumes: acs_pkg and acs_status_trig compiled first; an irq mask bit of one enables that source
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fail_count++; \
   $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end

module acs_status_trig_tb;
   logic             mclk_in;
   logic             rst_in;
   logic [9:0]       avs_address_in;
   logic             avs_read_in;
   logic             avs_write_in;
   logic [31:0]      avs_writedata_in;
   logic [3:0]       avs_byteenable_in;
   logic [31:0]      avs_readdata_out;
   logic             avs_waitrequest_out;
   acs_pkg::acs_dp_s dp;
   logic [2:0]       stage_in;
   logic             rc_clk_sel_in;
   logic             fosc_slower_in;
   logic [31:0]      trig_lines_in;
   logic [7:0]       ioc_flags_in;
   logic             chan_sel_wr_in;
   logic             result_high_rd_in;
   logic             error_high_rd_in;
   logic             conv_start_out;
   logic             neg_ref_select_out;
   logic [1:0]       pos_ref_select_out;
   logic             stage_valid_out;
   logic             irq_out;
   logic [7:0]       rd;
   int               fail_count;
   int               compares;
   int               starts;
   logic [4:0]       codes [18] = '{5'h1f, 5'h1d, 5'h1c, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h11,
                                    5'h12, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h1a, 5'h1b, 5'h1e, 5'h00};

   acs_status_trig DUT (
      .mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .dp_in(dp), .stage_in(stage_in),
      .rc_clk_sel_in(rc_clk_sel_in), .fosc_slower_in(fosc_slower_in), .trig_lines_in(trig_lines_in),
      .ioc_flags_in(ioc_flags_in), .chan_sel_wr_in(chan_sel_wr_in), .result_high_rd_in(result_high_rd_in),
      .error_high_rd_in(error_high_rd_in), .conv_start_out(conv_start_out),
      .neg_ref_select_out(neg_ref_select_out), .pos_ref_select_out(pos_ref_select_out),
      .stage_valid_out(stage_valid_out), .irq_out(irq_out));

   initial begin
      mclk_in = 1'b0;
      forever #12.5 mclk_in = ~mclk_in;
   end

   always @(posedge mclk_in) if (conv_start_out === 1'b1) starts++;

   // ==========================================================================
   // bus and stimulus tasks
   // ==========================================================================
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up

   // request held until waitrequest is sampled low, then released
   task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
      int n;
      n = 0;
      avs_address_in <= a;
      avs_writedata_in <= {24'h0, d};
      avs_write_in <= wr;
      avs_read_in <= ~wr;
      do begin
         @(posedge mclk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 20);
      if (avs_waitrequest_out !== 1'b0) begin
         fail_count++;
         $display("mismatch at %0t: bus timeout", $time);
         wrap_up();
      end
      rd = avs_readdata_out[7:0];
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      @(posedge mclk_in);
   endtask : bus

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      `CHK(rd, exp)
   endtask : rd_chk

   task automatic trig(input logic [4:0] code, input logic en, input int exp);
      wr(acs_pkg::IDX_CTRL, {7'h00, en});
      wr(acs_pkg::IDX_TRIGSEL, {3'h0, code});
      starts = 0;
      case (code)
         5'h1f: chan_sel_wr_in <= 1'b1;
         5'h1d: result_high_rd_in <= 1'b1;
         5'h1c: error_high_rd_in <= 1'b1;
         5'h13: ioc_flags_in <= 8'h20;
         default: trig_lines_in[code] <= 1'b1;
      endcase
      @(posedge mclk_in);
      chan_sel_wr_in <= 1'b0;
      result_high_rd_in <= 1'b0;
      error_high_rd_in <= 1'b0;
      ioc_flags_in <= 8'h00;
      trig_lines_in <= 32'h0;
      repeat (4) @(posedge mclk_in);
      `CHK(starts, exp)
   endtask : trig

   // mode bit 3 is the double-sample enable
   task automatic calc(input logic [3:0] mode, input int res, prv, sp, up, lo, input logic [7:0] exp);
      wr(acs_pkg::IDX_CTRL, {1'b0, mode[2:0], mode[3], 3'h1});
      dp.result <= 16'(res);
      dp.prev <= 16'(prv);
      dp.setpoint <= 16'(sp);
      dp.upper_thr <= 16'(up);
      dp.lower_thr <= 16'(lo);
      dp.compute_done <= 1'b1;
      @(posedge mclk_in);
      dp.compute_done <= 1'b0;
      repeat (2) @(posedge mclk_in);
      rd_chk(acs_pkg::IDX_STATUS, exp);
   endtask : calc

   // ==========================================================================
   // main sequence
   // ==========================================================================
   initial begin
      fail_count = 0;
      compares = 0;
      starts = 0;
      rst_in = 1'b1;
      avs_address_in = 10'h0;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_writedata_in = 32'h0;
      avs_byteenable_in = 4'h1;
      dp = '0;
      stage_in = 3'h0;
      rc_clk_sel_in = 1'b0;
      fosc_slower_in = 1'b0;
      trig_lines_in = 32'h0;
      ioc_flags_in = 8'h00;
      chan_sel_wr_in = 1'b0;
      result_high_rd_in = 1'b0;
      error_high_rd_in = 1'b0;
      repeat (6) @(posedge mclk_in);
      rst_in <= 1'b0;
      @(posedge mclk_in);
      rd_chk(acs_pkg::IDX_STATUS, 8'h00);
      rd_chk(acs_pkg::IDX_REFSEL, 8'h00);
      rd_chk(acs_pkg::IDX_TRIGSEL, 8'h00);
      rd_chk(10'h3ff, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         wr(acs_pkg::IDX_REFSEL, {3'h0, i[0], 2'h0, i[1:0]});
         repeat (2) @(posedge mclk_in);
         `CHK(neg_ref_select_out, i[0])
         `CHK(pos_ref_select_out, i[1:0])
         rd_chk(acs_pkg::IDX_REFSEL, {3'h0, i[0], 2'h0, i[1:0]});
      end
      avs_byteenable_in <= 4'h0;
      wr(acs_pkg::IDX_REFSEL, 8'h00);
      avs_byteenable_in <= 4'h1;
      rd_chk(acs_pkg::IDX_REFSEL, 8'h13);
      $display("test references done");
      for (int i = 0; i < 18; i++) begin
         trig(codes[i], 1'b1, (i < 14) ? 1 : 0);
      end
      trig(5'h1f, 1'b0, 0);
      trig(5'h14, 1'b0, 0);
      $display("test triggers done");
      wr(acs_pkg::IDX_IRQ_STAT, 8'h1f);
      rd_chk(acs_pkg::IDX_IRQ_STAT, 8'h00);
      wr(acs_pkg::IDX_IRQ_MASK, 8'h01);
      trig(5'h1f, 1'b1, 1);
      `CHK(irq_out, 1'b1)
      rd_chk(acs_pkg::IDX_IRQ_STAT, 8'h01);
      wr(acs_pkg::IDX_IRQ_MASK, 8'h00);
      repeat (2) @(posedge mclk_in);
      `CHK(irq_out, 1'b0)
      wr(acs_pkg::IDX_IRQ_MASK, 8'h01);
      repeat (2) @(posedge mclk_in);
      `CHK(irq_out, 1'b1)
      wr(acs_pkg::IDX_IRQ_STAT, 8'h01);
      repeat (2) @(posedge mclk_in);
      `CHK(irq_out, 1'b0)
      wr(acs_pkg::IDX_IRQ_MASK, 8'h00);
      $display("test interrupt done");
      calc(4'h1, 100, 0, 40, 60, 60, 8'h10);
      calc(4'h1, 100, 0, 40, 59, 61, 8'h70);
      calc(4'h9, 100, 30, 20, 60, 60, 8'h30);
      calc(4'h4, 0, 30, 0, 29, 31, 8'h70);
      calc(4'h5, 0, 0, 25, -30, -20, 8'h70);
      calc(4'h0, 10, 30, 0, 100, -19, 8'h30);
      wr(acs_pkg::IDX_STATUS, 8'h00);
      repeat (5) @(posedge mclk_in);
      rd_chk(acs_pkg::IDX_STATUS, 8'h20);
      wr(acs_pkg::IDX_STATUS, 8'hff);
      rd_chk(acs_pkg::IDX_STATUS, 8'h20);
      dp.accum_ovf <= 1'b1;
      repeat (3) @(posedge mclk_in);
      rd_chk(acs_pkg::IDX_STATUS, 8'hb0);
      dp.accum_ovf <= 1'b0;
      repeat (3) @(posedge mclk_in);
      wr(acs_pkg::IDX_STATUS, 8'h00);
      rd_chk(acs_pkg::IDX_STATUS, 8'h20);
      $display("test status flags done");
      for (int i = 0; i < 8; i++) begin
         stage_in <= i[2:0];
         repeat (3) @(posedge mclk_in);
         rd_chk(acs_pkg::IDX_STATUS, {5'h04, (i == 4) ? 3'h3 : i[2:0]});
      end
      rc_clk_sel_in <= 1'b1;
      repeat (3) @(posedge mclk_in);
      `CHK(stage_valid_out, 1'b1)
      fosc_slower_in <= 1'b1;
      repeat (3) @(posedge mclk_in);
      `CHK(stage_valid_out, 1'b0)
      rc_clk_sel_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
      `CHK(stage_valid_out, 1'b1)
      $display("test stage done");
      calc(4'h1, 32767, 0, -32768, 0, 0, 8'hd7);
      rst_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      rst_in <= 1'b0;
      @(posedge mclk_in);
      rd_chk(acs_pkg::IDX_STATUS, 8'h07);
      $display("test overflow and reset done");
      wrap_up();
   end
endmodule : acs_status_trig_tb
`default_nettype wire
